// ### dv/dual_port_sram_block_sva.sv
// checker for the dual-port memory block ports
`timescale 1ns/1ns
module dual_port_sram_block_sva (
    // system
    input wire logic                                ref_clk,
    input wire logic                                sys_rst,
    // configuration
    input wire dual_port_sram_block_pkg::org_t      organisation,
    input wire dual_port_sram_block_pkg::edge_pol_t write_clk_polarity,
    input wire dual_port_sram_block_pkg::edge_pol_t read_clk_polarity,
    // port activity
    input wire logic                                write_clk,
    input wire logic                                write_en,
    input wire logic                                read_clk,
    input wire logic [7:0]                          read_data_out,
    input wire logic                                read_valid,
    input wire logic                                write_done
);
    logic prev_w, prev_r, primed, wedge, redge;
    always_ff @(posedge ref_clk) begin
        prev_w <= write_clk;
        prev_r <= read_clk;
        primed <= !sys_rst;
    end
    assign wedge = primed && write_clk != write_clk_polarity
                   && prev_w == write_clk_polarity;
    assign redge = primed && read_clk != read_clk_polarity
                   && prev_r == read_clk_polarity;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wtake; wedge && write_en; endsequence
    sequence s_rtake; redge; endsequence
    a_write_done_due: assert property (s_wtake |=> write_done)
        else $error("write_done missing after write edge");
    a_write_done_cause: assert property (!(wedge && write_en) |=> !write_done)
        else $error("write_done without a write edge");
    a_read_valid_due: assert property (s_rtake |=> read_valid)
        else $error("read_valid missing after read edge");
    a_read_valid_cause: assert property (!redge |=> !read_valid)
        else $error("read_valid without a read edge");
    a_read_data_holds: assert property (!redge |=> $stable(read_data_out))
        else $error("read data changed without a read edge");
    a_nibble_upper_zero: assert property (
        s_rtake ##0 (organisation == dual_port_sram_block_pkg::ORG_64X4)
        |=> read_data_out[7:4] == 4'h0)
        else $error("upper read nibble not zero in nibble mode");
    a_ports_concurrent: assert property (s_wtake and s_rtake
        |=> read_valid && write_done)
        else $error("ports did not act together");
    a_reset_outputs: assert property ($fell(sys_rst) |-> read_data_out == 8'h00
        && !read_valid && !write_done)
        else $error("outputs not cleared by reset");
endmodule : dual_port_sram_block_sva
bind dual_port_sram_block dual_port_sram_block_sva u_sva (.ref_clk, .sys_rst,
    .organisation, .write_clk_polarity, .read_clk_polarity, .write_clk,
    .write_en, .read_clk, .read_data_out, .read_valid, .write_done);

// ### dv/port_clk_driver.sv
// user-logic model that pulses one port clock per request
`timescale 1ns/1ns
module port_clk_driver (
    // system
    input  wire logic                                ref_clk,
    input  wire logic                                sys_rst,
    // request and port clock
    input  wire logic                                fire,
    input  wire dual_port_sram_block_pkg::edge_pol_t pol,
    output logic                                     port_clk
);
    logic next_port_clk;
    // idles at the inactive level, one active cycle per request
    always_comb next_port_clk = (fire && !sys_rst) ? ~pol : pol;
    always_ff @(posedge ref_clk) port_clk <= next_port_clk;
endmodule : port_clk_driver

// ### dv/testbench.sv
// self-checking bench for the dual-port memory block
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module testbench;
    typedef struct {logic org, wen; logic [5:0] wa; logic [7:0] wd;
                    logic ren; logic [5:0] ra; logic [7:0] exp;} row_t;
    logic ref_clk, sys_rst, write_en, fire_w, fire_r, write_clk, read_clk;
    logic read_valid, write_done;
    logic [5:0] waddr, raddr;
    logic [7:0] wdata, read_data_out, last;
    dual_port_sram_block_pkg::org_t organisation;
    dual_port_sram_block_pkg::edge_pol_t wpol, rpol;
    int n_mismatch, compares;
    row_t rows[7] = '{'{1, 1, 6'h03, 8'ha5, 0, 6'h00, 8'h00},
        '{1, 0, 6'h03, 8'h11, 1, 6'h23, 8'ha5}, '{0, 1, 6'h3f, 8'hfc, 1, 6'h07, 8'h0a},
        '{0, 0, 6'h00, 8'h00, 1, 6'h06, 8'h05}, '{1, 1, 6'h3e, 8'h3c, 1, 6'h03, 8'ha5},
        '{0, 0, 6'h00, 8'h00, 1, 6'h3f, 8'h0c}, '{1, 0, 6'h00, 8'h00, 1, 6'h1e, 8'h3c}};
    dual_port_sram_block u_dual_port_sram_block (.ref_clk, .sys_rst, .organisation,
        .write_clk_polarity(wpol), .read_clk_polarity(rpol), .write_clk, .write_en,
        .write_word_address(waddr), .write_data_in(wdata), .read_clk,
        .read_word_address(raddr), .read_data_out, .read_valid, .write_done);
    port_clk_driver u_wr_clk (.ref_clk, .sys_rst, .fire(fire_w), .pol(wpol),
        .port_clk(write_clk));
    port_clk_driver u_rd_clk (.ref_clk, .sys_rst, .fire(fire_r), .pol(rpol),
        .port_clk(read_clk));
    task automatic op(row_t r);
        @(posedge ref_clk); #1;
        organisation = dual_port_sram_block_pkg::org_t'(r.org);
        write_en = r.wen; waddr = r.wa; wdata = r.wd; raddr = r.ra;
        fire_w = 1'b1; fire_r = r.ren;
        @(posedge ref_clk); #1;
        fire_w = 1'b0; fire_r = 1'b0;
        @(posedge ref_clk); #1;
        `CHK("write_done", r.wen, write_done)
        `CHK("read_valid", r.ren, read_valid)
        `CHK("read_data_out", r.ren ? r.exp : last, read_data_out)
        if (r.ren) last = r.exp;
    endtask : op
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #5000 n_mismatch++;
        stop_test();
    end
    initial begin
        {sys_rst, waddr, wdata, raddr} = '1;
        {write_en, fire_w, fire_r, last} = '0;
        organisation = dual_port_sram_block_pkg::ORG_32X8;
        wpol = dual_port_sram_block_pkg::EDGE_RISING;
        rpol = dual_port_sram_block_pkg::EDGE_RISING;
        repeat (5) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        `CHK("reset data", 8'h00, read_data_out)
        $display("test reset clears outputs done");
        for (int p = 0; p < 2; p++) begin
            foreach (rows[i]) op(rows[i]);
            wpol = dual_port_sram_block_pkg::EDGE_FALLING;
            rpol = dual_port_sram_block_pkg::EDGE_FALLING;
            $display("test rows pass %0d done", p);
        end
        @(posedge ref_clk); #1 sys_rst = 1'b1;
        @(posedge ref_clk); #1 sys_rst = 1'b0;
        `CHK("mid reset data", 8'h00, read_data_out)
        last = 8'h00;
        op('{1, 0, 6'h00, 8'h00, 1, 6'h03, 8'ha5});
        $display("test reset keeps memory done");
        stop_test();
    end
endmodule : testbench

// ### src/dual_port_sram_block.sv
// 256-bit dual-port memory block, 64x4 or 32x8
//
// Functional notes
// RULE_01: 256 bits of storage, organised as 64x4 or 32x8.
// RULE_02: read and write ports run independently and may act together.
// RULE_03: each port takes a six-bit word address covering 64 nibbles.
// RULE_04: in 32x8 organisation the top address bit of each port is ignored.
// RULE_05: separate read and write clocks, each with selectable active edge.
// RULE_06: eight write inputs, eight read outputs; 64x4 uses low half only.
// RULE_07: user logic may cascade blocks for width and depth.
// RULE_08: write stores on active write edge with enable; read follows edge.
`timescale 1ns/1ns

`include "dual_port_sram_block_map.svh"

module dual_port_sram_block #(
    parameter int ADDR_WIDTH   = `DPSB_ADDR_WIDTH,
    parameter int DATA_WIDTH   = `DPSB_DATA_WIDTH,
    parameter int NIBBLE_WIDTH = `DPSB_NIBBLE_WIDTH,
    parameter int NIBBLE_WORDS = `DPSB_NIBBLE_WORDS
) (
    // system
    input  wire logic                                ref_clk,
    input  wire logic                                sys_rst,
    // configuration
    input  wire dual_port_sram_block_pkg::org_t      organisation,
    input  wire dual_port_sram_block_pkg::edge_pol_t write_clk_polarity,
    input  wire dual_port_sram_block_pkg::edge_pol_t read_clk_polarity,
    // write port
    input  wire logic                                write_clk,
    input  wire logic                                write_en,
    input  wire logic [ADDR_WIDTH-1:0]               write_word_address,
    input  wire logic [DATA_WIDTH-1:0]               write_data_in,
    // read port
    input  wire logic                                read_clk,
    input  wire logic [ADDR_WIDTH-1:0]               read_word_address,
    output logic      [DATA_WIDTH-1:0]               read_data_out,
    output logic                                     read_valid,
    // write status
    output logic                                     write_done
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // the array is kept as nibbles; a byte is an adjacent even/odd pair
    logic [NIBBLE_WIDTH-1:0] mem [NIBBLE_WORDS]; // RULE_01
    logic [NIBBLE_WIDTH-1:0] next_mem [NIBBLE_WORDS];

    logic [DATA_WIDTH-1:0]   next_read_data_out;
    logic                    next_read_valid;
    logic                    next_write_done;

    logic                    write_edge;
    logic                    read_edge;
    logic                    byte_mode;

    logic [ADDR_WIDTH-1:0]   wr_lo_addr;
    logic [ADDR_WIDTH-1:0]   wr_hi_addr;
    logic [ADDR_WIDTH-1:0]   rd_lo_addr;
    logic [ADDR_WIDTH-1:0]   rd_hi_addr;
    logic [DATA_WIDTH-1:0]   read_word;

    // lane strobes and the nibbles on either side of the array
    logic                    wr_take;
    logic                    wr_hi_take;
    logic [NIBBLE_WIDTH-1:0] wr_lo_nibble;
    logic [NIBBLE_WIDTH-1:0] wr_hi_nibble;
    logic [NIBBLE_WIDTH-1:0] rd_lo_nibble;
    logic [NIBBLE_WIDTH-1:0] rd_hi_nibble;

    // ------------------------------------------------------------------
    // organisation
    // ------------------------------------------------------------------
    // organisation only changes how nibbles pair; stored bits stay put
    always_comb begin
        byte_mode = (organisation == dual_port_sram_block_pkg::ORG_32X8);
    end

    // ------------------------------------------------------------------
    // port clock edges
    // ------------------------------------------------------------------
    // each port clock is sampled on ref_clk; the two detectors share
    // nothing, so the ports never wait on one another
    port_clock_edge u_write_edge (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .clk_level   (write_clk),
        .polarity    (write_clk_polarity),
        .active_edge (write_edge)
    ); // RULE_05

    port_clock_edge u_read_edge (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .clk_level   (read_clk),
        .polarity    (read_clk_polarity),
        .active_edge (read_edge)
    ); // RULE_05

    // ------------------------------------------------------------------
    // address mapping
    // ------------------------------------------------------------------
    // byte mode drops the top bit and addresses a nibble pair
    always_comb begin
        if (byte_mode) begin
            wr_lo_addr = {write_word_address[ADDR_WIDTH-2:0], 1'b0}; // RULE_04
            wr_hi_addr = {write_word_address[ADDR_WIDTH-2:0], 1'b1}; // RULE_04
        end else begin
            wr_lo_addr = write_word_address; // RULE_03
            wr_hi_addr = write_word_address; // RULE_03
        end
    end

    // the read port maps its own address the same way
    always_comb begin
        if (byte_mode) begin
            rd_lo_addr = {read_word_address[ADDR_WIDTH-2:0], 1'b0}; // RULE_04
            rd_hi_addr = {read_word_address[ADDR_WIDTH-2:0], 1'b1}; // RULE_04
        end else begin
            rd_lo_addr = read_word_address; // RULE_03
            rd_hi_addr = read_word_address; // RULE_03
        end
    end

    // ------------------------------------------------------------------
    // write port
    // ------------------------------------------------------------------
    // a write is taken only on the active write edge with the enable up;
    // the high lane follows only in byte mode
    always_comb begin
        wr_take      = write_edge & write_en; // RULE_08
        wr_hi_take   = wr_take & byte_mode; // RULE_06
        wr_lo_nibble = write_data_in[`DPSB_LOW_NIBBLE_LSB +: NIBBLE_WIDTH];
        wr_hi_nibble = write_data_in[`DPSB_HIGH_NIBBLE_LSB +: NIBBLE_WIDTH];
    end

    always_comb begin
        for (int i = 0; i < NIBBLE_WORDS; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr_take) begin
            next_mem[wr_lo_addr] = wr_lo_nibble; // RULE_08
        end
        if (wr_hi_take) begin
            next_mem[wr_hi_addr] = wr_hi_nibble; // RULE_06
        end
    end

    // no reset: stored contents are undefined until written
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NIBBLE_WORDS; i++) begin
            mem[i] <= next_mem[i];
        end
    end

    // ------------------------------------------------------------------
    // write status
    // ------------------------------------------------------------------
    // one-cycle pulse for every stored write
    always_comb begin
        next_write_done = wr_take; // RULE_02
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            write_done <= 1'b0;
        end else begin
            write_done <= next_write_done; // RULE_02
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // reads the array before this cycle's write, so a same-address
    // read and write in one cycle returns the old contents
    always_comb begin
        rd_lo_nibble = mem[rd_lo_addr]; // RULE_06
        if (byte_mode) begin
            rd_hi_nibble = mem[rd_hi_addr]; // RULE_06
        end else begin
            rd_hi_nibble = `DPSB_UPPER_FILL; // RULE_06
        end
        read_word = {rd_hi_nibble, rd_lo_nibble};
    end

    // read data holds until the next active read edge
    always_comb begin
        next_read_data_out = read_data_out;
        if (read_edge) begin
            next_read_data_out = read_word; // RULE_08
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            read_data_out <= `DPSB_READ_DATA_RST;
        end else begin
            read_data_out <= next_read_data_out;
        end
    end

    // ------------------------------------------------------------------
    // read status
    // ------------------------------------------------------------------
    // one-cycle pulse whenever new read data is loaded
    always_comb begin
        next_read_valid = read_edge; // RULE_02
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            read_valid <= 1'b0;
        end else begin
            read_valid <= next_read_valid;
        end
    end

endmodule : dual_port_sram_block

// ### src/dual_port_sram_block_map.svh
// constants for the dual-port memory block
`ifndef DUAL_PORT_SRAM_BLOCK_MAP_SVH
`define DUAL_PORT_SRAM_BLOCK_MAP_SVH

// ------------------------------------------------------------------
// geometry
// ------------------------------------------------------------------
`define DPSB_TOTAL_BITS     256
`define DPSB_ADDR_WIDTH     6
`define DPSB_DATA_WIDTH     8
`define DPSB_NIBBLE_WIDTH   4
`define DPSB_NIBBLE_WORDS   64
`define DPSB_BYTE_WORDS     32

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define DPSB_ADDR_MSB       5
`define DPSB_LOW_NIBBLE_LSB 0
`define DPSB_HIGH_NIBBLE_LSB 4

// ------------------------------------------------------------------
// reset and fill values
// ------------------------------------------------------------------
`define DPSB_READ_DATA_RST  8'h00
`define DPSB_UPPER_FILL     4'h0

`endif

// ### src/dual_port_sram_block_pkg.sv
// types shared by the dual-port memory block
package dual_port_sram_block_pkg;

    // word organisation of the 256-bit array
    typedef enum logic [0:0] {
        ORG_64X4 = 1'b0,
        ORG_32X8 = 1'b1
    } org_t;

    // active edge of a port clock
    typedef enum logic [0:0] {
        EDGE_RISING  = 1'b0,
        EDGE_FALLING = 1'b1
    } edge_pol_t;

endpackage : dual_port_sram_block_pkg

// ### src/port_clock_edge.sv
// active-edge detector for one sampled port clock
`timescale 1ns/1ns

module port_clock_edge (
    // system
    input  wire logic                              ref_clk,
    input  wire logic                              sys_rst,
    // port clock and its polarity
    input  wire logic                              clk_level,
    input  wire dual_port_sram_block_pkg::edge_pol_t polarity,
    // detected active edge, combinational
    output logic                                   active_edge
);

    logic prev_level;
    logic primed;
    logic next_prev_level;
    logic next_primed;
    logic rose;
    logic fell;

    // ------------------------------------------------------------------
    // edge decode
    // ------------------------------------------------------------------
    always_comb begin
        next_prev_level = clk_level;
        next_primed     = 1'b1;
        rose            = primed & clk_level & ~prev_level;
        fell            = primed & ~clk_level & prev_level;
        if (polarity == dual_port_sram_block_pkg::EDGE_FALLING) begin
            active_edge = fell; // RULE_05
        end else begin
            active_edge = rose; // RULE_05
        end
    end

    // ------------------------------------------------------------------
    // history
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_level <= 1'b0;
            primed     <= 1'b0;
        end else begin
            prev_level <= next_prev_level;
            primed     <= next_primed;
        end
    end

endmodule : port_clock_edge
